// file: design/ata_wm_regs.svh
// Register offsets, field positions and fixed values of the block-write engine
`ifndef ATA_WM_REGS_SVH
`define ATA_WM_REGS_SVH
`define OFS_DATA 8'h00
`define OFS_FEATURE 8'h04
`define OFS_COUNT_CUR 8'h08
`define OFS_COUNT_PREV 8'h0C
`define OFS_SECNUM_CUR 8'h10
`define OFS_SECNUM_PREV 8'h14
`define OFS_CYLLO_CUR 8'h18
`define OFS_CYLLO_PREV 8'h1C
`define OFS_CYLHI_CUR 8'h20
`define OFS_CYLHI_PREV 8'h24
`define OFS_DEV_HEAD 8'h28
`define OFS_CMD 8'h2C
`define OFS_ERROR 8'h30
`define OFS_DEV_CTRL 8'h34
`define OFS_BLOCK_SIZE 8'h38
`define OFS_IRQ_STATUS 8'h3C
`define OFS_IRQ_MASK 8'h40
`define CMD_WM28 8'hC5
`define CMD_WM48 8'h39
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_SEEK 4
`define ST_DRQ 3
`define ST_CORR 2
`define ST_INDEX 1
`define ST_ERR 0
`define ER_IDN 4
`define ER_ABT 2
`define DH_LBA 6
`define DC_HOB 7
`define IRQ_BLOCK 0
`define IRQ_DONE 1
`define IRQ_ERR 2
`define IRQ_BITS 3
`define CNT28_ZERO 17'h00100
`define CNT48_ZERO 17'h10000
`define CNT_ONE 17'h00001
`define CHS_FIRST_SECTOR 8'h01
`define BLK_ONE 8'h01
`endif

// file: design/ata_wm_pkg.sv
// Types shared by the block-write engine
package ata_wm_pkg;
    // Command sequencer states
    typedef enum logic [2:0] {S_IDLE, S_DATA, S_COMMIT, S_WAIT} wm_state_t;
    // Start address, 48 bits wide
    typedef logic [47:0] lba_t;
endpackage

// file: design/sector_buf_if.sv
// Carrier between the engine and its sector buffer
`timescale 1ns/1ps
interface sector_buf_if #(parameter int W = 16, parameter int A = 8);
    logic wr_en;
    logic [A-1:0] wr_addr;
    logic [W-1:0] wr_data;
    logic [A-1:0] rd_addr;
    logic [W-1:0] rd_data;
    modport owner (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// file: design/sector_buffer.sv
// One-sector word store with registered read data
`timescale 1ns/1ps
module sector_buffer #(parameter int W = 16, parameter int A = 8)
(
    // Clock
    input wire logic clk,
    // Engine side
    sector_buf_if.store sb
);
    // Storage, no reset needed
    logic [W-1:0] mem [0:(2**A)-1];

    // Write port
    always_ff @(posedge clk)
    begin
        if (sb.wr_en)
        begin
            mem[sb.wr_addr] <= sb.wr_data;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk)
    begin
        sb.rd_data <= mem[sb.rd_addr];
    end
endmodule

// file: design/ata_write_multiple.sv
// Block-write command engine with Wishbone task file and media stream
//
// Contract
// - Code C5h starts the 28-bit block write
// - Code 39h starts the 48-bit block write
// - Accept host sectors, then commit to media
// - Like single-sector write, interrupt per block
// - Data register carries one 16-bit word
// - 28-bit count zero means 256 sectors
// - 48-bit count is previous:current bytes
// - 48-bit count zero means 65536 sectors
// - Addressing bit clear selects cylinder-head-sector for 28-bit only
// - Addressing bit set forms 28-bit block address
// - 48-bit address from current and previous bytes
// - 28-bit count reads back sectors not written
// - 28-bit address reads back last sector written
// - 48-bit failure reports first failing address
// - End status clean; only abort, id-not-found
`timescale 1ns/1ps
`include "ata_wm_regs.svh"
module ata_write_multiple
    import ata_wm_pkg::*;
#(
    parameter int WORDS = 256,
    parameter int AW = 8,
    parameter logic [7:0] SECTORS_PER_TRACK = 8'h3F,
    parameter logic [3:0] LAST_HEAD = 4'hF
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq,
    // Media stream
    output logic media_valid,
    output logic media_first,
    output logic [15:0] media_data,
    output logic [47:0] media_lba,
    output logic media_chs,
    input wire logic media_done,
    input wire logic media_fail
);
    // Sequencer state
    wm_state_t state;
    wm_state_t next_state;
    // Task file bytes
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] secnum_cur;
    logic [7:0] secnum_prev;
    logic [7:0] cyllo_cur;
    logic [7:0] cyllo_prev;
    logic [7:0] cylhi_cur;
    logic [7:0] cylhi_prev;
    logic [7:0] dev_head;
    logic [7:0] feature;
    logic [7:0] dev_ctrl;
    logic [7:0] block_size;
    // Status and error flags
    logic busy_flag;
    logic err_flag;
    logic command_abort_error;
    logic id_not_found_error;
    // Command progress
    logic is48;
    logic chs_mode;
    lba_t addr;
    lba_t last_addr;
    logic [16:0] cnt;
    logic [7:0] blk_left;
    logic [AW-1:0] widx;
    logic [AW-1:0] ridx;
    logic issue;
    logic issue_first;
    // Interrupt registers
    logic [`IRQ_BITS-1:0] irq_stat;
    logic [`IRQ_BITS-1:0] irq_mask;

    // Sector buffer
    sector_buf_if #(.W(16), .A(AW)) sb ();
    sector_buffer #(.W(16), .A(AW)) u_buf (.clk(clk), .sb(sb));

    // Bus decode
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = wb_req & wb_we_i;
    wire bus_rd = wb_req & ~wb_we_i;
    wire byte_wr = bus_wr & wb_sel_i[0];
    wire idle = (state == S_IDLE);
    // Task file is frozen while a command runs
    wire tf_wr = byte_wr & idle;
    wire cmd_go = tf_wr & (wb_adr_i == `OFS_CMD);
    wire code28 = (wb_dat_i[7:0] == `CMD_WM28);
    wire code48 = (wb_dat_i[7:0] == `CMD_WM48);
    // Without a block size the command cannot run, so it aborts
    wire go_ok = cmd_go & (code28 | code48) & (block_size != 8'h00);
    wire go_bad = cmd_go & ~go_ok;
    // Both low byte lanes needed for a data word
    wire data_wr = bus_wr & (&wb_sel_i[1:0]) & (wb_adr_i == `OFS_DATA) &
        (state == S_DATA);
    wire word_last = (widx == AW'(WORDS - 1));
    wire read_last = (ridx == AW'(WORDS - 1));
    wire high_order_readback = dev_ctrl[`DC_HOB];

    // Requested sector counts
    wire [16:0] req28 = (count_cur == 8'h00) ? `CNT28_ZERO
        : {9'h000, count_cur};
    wire [15:0] cnt16 = {count_prev, count_cur};
    wire [16:0] req48 = (cnt16 == 16'h0000) ? `CNT48_ZERO
        : {1'b0, cnt16};

    // Start addresses
    wire [47:0] start48 = {cylhi_prev, cyllo_prev, secnum_prev,
        cylhi_cur, cyllo_cur, secnum_cur};
    // Same packing serves block and head/cylinder/sector forms
    wire [47:0] start28 = {20'h00000, dev_head[3:0], cylhi_cur,
        cyllo_cur, secnum_cur};

    // Sector completion events
    wire in_wait = (state == S_WAIT) & media_done;
    wire sector_ok = in_wait & ~media_fail;
    wire sector_bad = in_wait & media_fail;
    wire last_sector = (cnt == `CNT_ONE);
    wire block_end = (blk_left == `BLK_ONE);
    wire finish = (sector_ok & last_sector) | sector_bad;
    // Final shorter group still closes a block
    wire ev_block = sector_ok & (last_sector | block_end);
    wire ev_done = finish | go_bad;
    wire ev_err = sector_bad | go_bad;
    wire [`IRQ_BITS-1:0] irq_ev = {ev_err, ev_done, ev_block};
    wire irq_clr = bus_rd & (wb_adr_i == `OFS_IRQ_STATUS);

    // Values left behind at the end of a command
    wire [16:0] left = sector_bad ? cnt : (cnt - `CNT_ONE);
    wire lba_t next_addr = step_addr(addr, chs_mode);
    // 28-bit reports last written, 48-bit failure reports failing one
    wire lba_t report = sector_ok ? addr
        : (is48 ? addr : last_addr);

    // Status byte, fault and corrected-data always clear
    wire [7:0] status = {busy_flag, 1'b1, 1'b0, 1'b1,
        (state == S_DATA), 1'b0, 1'b0, err_flag};
    wire [7:0] errors = {3'b000, id_not_found_error, 1'b0,
        command_abort_error, 2'b00};

    // Read multiplexer, previous bytes under high-order readback
    wire [7:0] rd_byte =
        (wb_adr_i == `OFS_FEATURE) ? feature :
        (wb_adr_i == `OFS_COUNT_CUR) ? (high_order_readback ? count_prev : count_cur) :
        (wb_adr_i == `OFS_COUNT_PREV) ? count_prev :
        (wb_adr_i == `OFS_SECNUM_CUR) ? (high_order_readback ? secnum_prev : secnum_cur) :
        (wb_adr_i == `OFS_SECNUM_PREV) ? secnum_prev :
        (wb_adr_i == `OFS_CYLLO_CUR) ? (high_order_readback ? cyllo_prev : cyllo_cur) :
        (wb_adr_i == `OFS_CYLLO_PREV) ? cyllo_prev :
        (wb_adr_i == `OFS_CYLHI_CUR) ? (high_order_readback ? cylhi_prev : cylhi_cur) :
        (wb_adr_i == `OFS_CYLHI_PREV) ? cylhi_prev :
        (wb_adr_i == `OFS_DEV_HEAD) ? dev_head :
        (wb_adr_i == `OFS_CMD) ? status :
        (wb_adr_i == `OFS_ERROR) ? errors :
        (wb_adr_i == `OFS_DEV_CTRL) ? dev_ctrl :
        (wb_adr_i == `OFS_BLOCK_SIZE) ? block_size :
        (wb_adr_i == `OFS_IRQ_STATUS) ? {5'h00, irq_stat} :
        (wb_adr_i == `OFS_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

    // Buffer ports
    assign sb.wr_en = data_wr;
    assign sb.wr_addr = widx;
    assign sb.wr_data = wb_dat_i[15:0];
    assign sb.rd_addr = ridx;

    // Next sector address, block or head/cylinder/sector stepping
    function automatic lba_t step_addr(input lba_t a, input logic chs);
        lba_t n;
        begin
            n = a + 48'h000000000001;
            if (chs)
            begin
                if (a[7:0] != SECTORS_PER_TRACK)
                    n = {a[47:8], a[7:0] + 8'h01};
                else if (a[27:24] != LAST_HEAD)
                    n = {a[47:28], a[27:24] + 4'h1, a[23:8],
                        `CHS_FIRST_SECTOR};
                else
                    n = {a[47:28], 4'h0, a[23:8] + 16'h0001,
                        `CHS_FIRST_SECTOR};
            end
            return n;
        end
    endfunction

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:
            begin
                // Valid code opens the first data block
                if (go_ok)
                    next_state = S_DATA;
            end
            S_DATA:
            begin
                // Full sector received, commit it
                if (data_wr & word_last)
                    next_state = S_COMMIT;
            end
            S_COMMIT:
            begin
                if (read_last)
                    next_state = S_WAIT;
            end
            S_WAIT:
            begin
                if (finish)
                    next_state = S_IDLE;
                else if (sector_ok)
                    next_state = S_DATA;
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // Wishbone answer, one wait cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Task file: host writes when idle, engine writes back at end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_cur <= 8'h00;
            count_prev <= 8'h00;
            secnum_cur <= 8'h00;
            secnum_prev <= 8'h00;
            cyllo_cur <= 8'h00;
            cyllo_prev <= 8'h00;
            cylhi_cur <= 8'h00;
            cylhi_prev <= 8'h00;
            dev_head <= 8'h00;
            feature <= 8'h00;
        end
        else if (finish)
        begin
            // Progress readback
            count_cur <= left[7:0];
            secnum_cur <= report[7:0];
            cyllo_cur <= report[15:8];
            cylhi_cur <= report[23:16];
            if (is48)
            begin
                count_prev <= left[15:8];
                secnum_prev <= report[31:24];
                cyllo_prev <= report[39:32];
                cylhi_prev <= report[47:40];
            end
            else
            begin
                dev_head[3:0] <= report[27:24];
            end
        end
        else if (tf_wr)
        begin
            // Host loads the block before issuing a command
            case (wb_adr_i)
                `OFS_FEATURE: feature <= wb_dat_i[7:0];
                `OFS_COUNT_CUR: count_cur <= wb_dat_i[7:0];
                `OFS_COUNT_PREV: count_prev <= wb_dat_i[7:0];
                `OFS_SECNUM_CUR: secnum_cur <= wb_dat_i[7:0];
                `OFS_SECNUM_PREV: secnum_prev <= wb_dat_i[7:0];
                `OFS_CYLLO_CUR: cyllo_cur <= wb_dat_i[7:0];
                `OFS_CYLLO_PREV: cyllo_prev <= wb_dat_i[7:0];
                `OFS_CYLHI_CUR: cylhi_cur <= wb_dat_i[7:0];
                `OFS_CYLHI_PREV: cylhi_prev <= wb_dat_i[7:0];
                `OFS_DEV_HEAD: dev_head <= wb_dat_i[7:0];
                default: feature <= feature;
            endcase
        end
    end

    // Control registers; device control and mask writable at any time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dev_ctrl <= 8'h00;
            block_size <= 8'h00;
            irq_mask <= 3'b000;
        end
        else if (byte_wr)
        begin
            if (wb_adr_i == `OFS_DEV_CTRL)
                dev_ctrl <= wb_dat_i[7:0];
            // Block size changes only between commands
            if ((wb_adr_i == `OFS_BLOCK_SIZE) & idle)
                block_size <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_IRQ_MASK)
                irq_mask <= wb_dat_i[`IRQ_BITS-1:0];
        end
    end

    // Status and error flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_flag <= 1'b0;
            err_flag <= 1'b0;
            command_abort_error <= 1'b0;
            id_not_found_error <= 1'b0;
        end
        else if (cmd_go)
        begin
            // New command clears old errors
            busy_flag <= 1'b0;
            err_flag <= go_bad;
            command_abort_error <= go_bad;
            id_not_found_error <= 1'b0;
        end
        else
        begin
            // Busy while a sector goes to media
            if ((state == S_DATA) & data_wr & word_last)
                busy_flag <= 1'b1;
            else if (in_wait)
                busy_flag <= 1'b0;
            if (sector_bad)
            begin
                err_flag <= 1'b1;
                id_not_found_error <= 1'b1;
            end
        end
    end

    // Command progress counters and addresses
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            is48 <= 1'b0;
            chs_mode <= 1'b0;
            addr <= 48'h000000000000;
            last_addr <= 48'h000000000000;
            cnt <= 17'h00000;
            blk_left <= 8'h00;
        end
        else if (go_ok)
        begin
            is48 <= code48;
            chs_mode <= code28 & ~dev_head[`DH_LBA];
            addr <= code48 ? start48 : start28;
            last_addr <= code48 ? start48 : start28;
            cnt <= code48 ? req48 : req28;
            blk_left <= block_size;
        end
        else if (sector_ok)
        begin
            last_addr <= addr;
            addr <= next_addr;
            cnt <= cnt - `CNT_ONE;
            blk_left <= block_end ? block_size : (blk_left - `BLK_ONE);
        end
    end

    // Word indices into the sector buffer
    always_ff @(posedge clk)
    begin
        if (rst | go_ok)
        begin
            widx <= '0;
            ridx <= '0;
        end
        else
        begin
            if (data_wr)
                widx <= widx + AW'(1);
            if (state == S_COMMIT)
                ridx <= ridx + AW'(1);
        end
    end

    // Media stream, two stages behind the buffer address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            issue <= 1'b0;
            issue_first <= 1'b0;
            media_valid <= 1'b0;
            media_first <= 1'b0;
            media_data <= 16'h0000;
            media_lba <= 48'h000000000000;
            media_chs <= 1'b0;
        end
        else
        begin
            issue <= (state == S_COMMIT);
            issue_first <= (state == S_COMMIT) & (ridx == '0);
            media_valid <= issue;
            media_first <= issue_first;
            media_data <= sb.rd_data;
            media_lba <= addr;
            media_chs <= chs_mode;
        end
    end

    // Sticky interrupt status, set wins over read clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_stat <= 3'b000;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_clr ? 3'b000 : irq_stat) | irq_ev;
            irq <= |(irq_stat & irq_mask);
        end
    end
endmodule

// file: dv/ata_wm_checker.sv
// Port-level checks of the block-write engine
`timescale 1ns/1ps
module ata_wm_checker #(parameter int WORDS = 256)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Media stream
    input wire logic media_valid,
    input wire logic media_first,
    input wire logic [47:0] media_lba,
    input wire logic media_chs
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Words seen so far in the running burst
    int burst_words;
    // Counter restarts on the first word so a lost pulse shows at the burst end
    always_ff @(posedge clk)
    begin
        if (rst || media_first)
            burst_words <= int'(media_first);
        else if (media_valid)
            burst_words <= burst_words + 1;
    end
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    first_valid_a: assert property (media_first |-> media_valid)
        else $error("first marker without valid");
    burst_start_a: assert property ($rose(media_valid) |-> media_first)
        else $error("burst not opened by first word");
    burst_len_a: assert property ($fell(media_valid) |-> burst_words == WORDS)
        else $error("sector burst length wrong");
    addr_steady_a: assert property (media_valid && !media_first |->
        $stable(media_lba) && $stable(media_chs))
        else $error("address moved inside a sector");
endmodule

bind ata_write_multiple ata_wm_checker #(.WORDS(WORDS)) i_chk (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .media_valid(media_valid), .media_first(media_first), .media_lba(media_lba),
    .media_chs(media_chs));

// file: dv/media_model.sv
// Media stand-in that acknowledges each committed sector
`timescale 1ns/1ps
module media_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stream from the engine
    input wire logic media_valid,
    // Failure request from the bench
    input wire logic fail_en,
    // Answer to the engine
    output logic media_done,
    output logic media_fail
);
    // Cycles left before the answer, 0 when idle
    int wait_cnt;
    // Random latency so both prompt and slow media occur
    always @(posedge clk)
    begin
        // Answer registered from the last count of 1, so it shows as the count reaches 0
        media_done <= !rst && !media_valid && wait_cnt == 1;
        media_fail <= !rst && !media_valid && wait_cnt == 1 && fail_en;
        if (rst)
            wait_cnt <= 0;
        else if (media_valid)
            wait_cnt <= 1 + $urandom_range(0, 9);
        else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the block-write engine
`timescale 1ns/1ps
`include "ata_wm_regs.svh"
module tb
    import ata_wm_pkg::*;
;
    localparam int WORDS = 4;
    // Bus, interrupt and media wiring
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, irq, mvalid, mfirst, mchs, mdone, mfail;
    logic [15:0] mdata;
    lba_t mlba;
    logic fail_en = 1'b0;
    // Byte lanes, narrowed once per command to probe the refused data write
    logic [3:0] sel = 4'hF;
    // Scoreboard
    int errors = 0;
    int check_count = 0;
    logic [15:0] word_q[$];
    lba_t lba_q[$];
    logic exp_chs = 1'b0;

    // 50 ns clock
    always #25 clk = ~clk;

    ata_write_multiple #(.WORDS(WORDS), .AW(2)) i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .media_valid(mvalid), .media_first(mfirst),
        .media_data(mdata), .media_lba(mlba), .media_chs(mchs), .media_done(mdone),
        .media_fail(mfail));
    media_model i_media (.clk(clk), .rst(rst), .media_valid(mvalid), .fail_en(fail_en),
        .media_done(mdone), .media_fail(mfail));

    task automatic finish_test;
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, {16'h0, d}, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, {40'h0, e}, {16'h0, q});
    endtask

    // Poll status until the engine is no longer busy
    task automatic wait_ready;
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            wb(1'b0, `OFS_CMD, 32'h0, q);
            n++;
        end
        while (q[7] !== 1'b0 && n < 400);
        if (q[7] !== 1'b0)
        begin
            errors++;
            finish_test();
        end
    endtask

    task automatic irqc(input logic [7:0] e);
        chk("irq", {47'h0, e != 8'h00}, {47'h0, irq});
        rdc(`OFS_IRQ_STATUS, e, "irq_status");
    endtask

    // Next sector address; CHS sector wraps to 1, then head, then cylinder
    function automatic lba_t step(input lba_t a, input logic chs);
        if (!chs || a[7:0] != 8'h3F)
            return a + 48'h1;
        if (a[27:24] != 4'hF)
            return {a[47:28], a[27:24] + 4'h1, a[23:8], 8'h01};
        return {a[47:28], 4'h0, a[23:8] + 16'h1, 8'h01};
    endfunction

    // Committed words and addresses against what was sent
    always @(posedge clk)
    begin
        if (!rst && mvalid === 1'b1)
        begin
            if (mfirst === 1'b1 && lba_q.size() > 0)
            begin
                chk("media_lba", lba_q.pop_front(), mlba);
                chk("media_chs", {47'h0, exp_chs}, {47'h0, mchs});
            end
            if (word_q.size() > 0)
                chk("media_data", {32'h0, word_q.pop_front()}, {32'h0, mdata});
        end
    end

    // Full command; fidx is the failing sector or -1
    task automatic run(input logic [7:0] cmd, input logic [15:0] cnt, input lba_t start,
        input logic chs, input logic [7:0] bs, input int fidx);
        int total;
        int last;
        lba_t a;
        lba_t p;
        logic [15:0] w;
        logic [31:0] q;
        logic wide;
        wide = cmd == `CMD_WM48;
        total = wide ? ((cnt == 0) ? 65536 : cnt) : ((cnt[7:0] == 0) ? 256 : cnt[7:0]);
        last = (fidx >= 0) ? fidx : total - 1;
        wr(`OFS_BLOCK_SIZE, bs);
        wr(`OFS_COUNT_CUR, cnt[7:0]);
        wr(`OFS_COUNT_PREV, cnt[15:8]);
        wr(`OFS_SECNUM_CUR, start[7:0]);
        wr(`OFS_SECNUM_PREV, start[31:24]);
        wr(`OFS_CYLLO_CUR, start[15:8]);
        wr(`OFS_CYLLO_PREV, start[39:32]);
        wr(`OFS_CYLHI_CUR, start[23:16]);
        wr(`OFS_CYLHI_PREV, start[47:40]);
        wr(`OFS_DEV_HEAD, {1'b1, !chs, 1'b1, 1'b0, start[27:24]});
        a = start;
        exp_chs = chs;
        wr(`OFS_CMD, cmd);
        for (int s = 0; s <= last; s++)
        begin
            wait_ready();
            if (s > 0)
                irqc((s % bs == 0) ? 8'h01 : 8'h00);
            rdc(`OFS_CMD, 8'h58, "status_drq");
            fail_en <= s == fidx;
            // One lane only: the word must not enter the sector
            if (s == 0)
            begin
                sel <= 4'h1;
                wr(`OFS_DATA, 16'hFFFF);
                sel <= 4'hF;
            end
            lba_q.push_back(a);
            for (int i = 0; i < WORDS; i++)
            begin
                w = 16'($urandom());
                word_q.push_back(w);
                wr(`OFS_DATA, w);
            end
            if (s < last)
            begin
                p = a;
                a = step(a, chs);
            end
        end
        // 28-bit failure reports the last good sector, the start if none
        if (!wide && fidx > 0)
            a = p;
        wait_ready();
        chk("media_left", 48'h0, 48'(word_q.size() + lba_q.size()));
        irqc((fidx >= 0) ? 8'h06 : 8'h03);
        rdc(`OFS_CMD, (fidx >= 0) ? 8'h51 : 8'h50, "status");
        rdc(`OFS_ERROR, (fidx >= 0) ? 8'h10 : 8'h00, "error");
        total = (fidx >= 0) ? total - fidx : 0;
        rdc(`OFS_COUNT_CUR, total[7:0], "count");
        rdc(`OFS_SECNUM_CUR, a[7:0], "sector");
        rdc(`OFS_CYLLO_CUR, a[15:8], "cyl_low");
        rdc(`OFS_CYLHI_CUR, a[23:16], "cyl_high");
        if (wide)
        begin
            wr(`OFS_DEV_CTRL, 8'h80);
            rdc(`OFS_COUNT_CUR, total[15:8], "count_prev");
            rdc(`OFS_SECNUM_CUR, a[31:24], "sector_prev");
            rdc(`OFS_CYLLO_CUR, a[39:32], "cyl_low_prev");
            rdc(`OFS_CYLHI_CUR, a[47:40], "cyl_high_prev");
            wr(`OFS_DEV_CTRL, 8'h00);
        end
        else
        begin
            wb(1'b0, `OFS_DEV_HEAD, 32'h0, q);
            chk("head", {44'h0, a[27:24]}, {44'h0, q[3:0]});
        end
        fail_en <= 1'b0;
    endtask

    // Refused command: bad code or zero block size
    task automatic abort(input logic [7:0] cmd, input logic [7:0] bs);
        wr(`OFS_BLOCK_SIZE, bs);
        wr(`OFS_CMD, cmd);
        wait_ready();
        irqc(8'h06);
        rdc(`OFS_CMD, 8'h51, "abort_status");
        rdc(`OFS_ERROR, 8'h04, "abort_error");
    endtask

    // Main sequence
    initial
    begin
        logic [31:0] r;
        void'($urandom(32'hC487));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`OFS_CMD, 8'h50, "reset_status");
        rdc(`OFS_ERROR, 8'h00, "reset_error");
        rdc(8'hFC, 8'h00, "unmapped");
        irqc(8'h00);
        wr(`OFS_IRQ_MASK, 8'h07);
        r = $urandom();
        run(`CMD_WM28, 16'h0003, {20'h0, r[27:0]}, 1'b0, 8'h02, -1);
        r = $urandom();
        run(`CMD_WM28, 16'h0000, {20'h0, r[27:0]}, 1'b0, 8'(1 + $urandom_range(0, 15)), -1);
        run(`CMD_WM28, 16'h0004, 48'h0F12343E, 1'b1, 8'h04, -1);
        r = $urandom();
        run(`CMD_WM48, 16'h0102, {r[15:0], $urandom()}, 1'b0, 8'h02, 2);
        run(`CMD_WM48, 16'h0000, {r[31:16], $urandom()}, 1'b0, 8'h03, 1);
        run(`CMD_WM28, 16'h0005, {20'h0, r[31:4]}, 1'b0, 8'h02, 3);
        abort(8'h30, 8'h02);
        abort(`CMD_WM28, 8'h00);
        finish_test();
    end
endmodule
